// [buffered_register_map_params.svh]
`ifndef BUFFERED_REGISTER_MAP_PARAMS_SVH
`define BUFFERED_REGISTER_MAP_PARAMS_SVH

// ----------------------------------------
// Map range and offsets
// ----------------------------------------
`define MAP_LAST_ADDR        16'h0E3F
`define ADDR_PORT_CONFIG     16'h0000
`define ADDR_SPARE_ONE       16'h0001
`define ADDR_SILICON_REV     16'h0002
`define ADDR_PART_ID         16'h0003
`define ADDR_READBACK_SEL    16'h0004
`define ADDR_UPDATE          16'h0005
`define ADDR_STEP_LOW        16'h0314
`define ADDR_STEP_HIGH       16'h0315
`define ADDR_SLOW_CONTROL    16'h0320
`define ADDR_STATUS_SNAP     16'h0D00
`define ADDR_SEQ_FIRST       16'h0E10
`define ADDR_SEQ_LAST        16'h0E3F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_READBACK_STAGED  0
`define BIT_UPDATE_TRIGGER   0
`define BIT_ACTION_REQUEST   0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PORT_CONFIG      8'h10
`define RST_SPARE_ONE        8'h00
`define RST_READBACK_SEL     8'h00
`define RST_STEP_SIZE        16'h03E8
`define RST_SLOW_CONTROL     8'h00
`define RST_STATUS_SNAP      8'h00
`define RST_SEQ_BYTE         8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYSTEM_CLOCK_DIVIDE  32

`endif

// [buffered_register_map_pkg.sv]
`default_nettype none

package buffered_register_map_pkg;

  // ----------------------------------------
  // Byte access request of one master
  // ----------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bus_req_t;

  // ----------------------------------------
  // System-clock class commit state
  // ----------------------------------------
  typedef enum logic [0:0] {
    COMMIT_IDLE    = 1'b0,
    COMMIT_PENDING = 1'b1
  } commit_state_t;

endpackage

`default_nettype wire

// [buffered_register_map_core.sv]
// Functional notes
// - Decode 0x0000..0x0E3F, one byte per address; only mapped addresses have storage.
// - Multi-byte fields: LSB at D0 of lowest address, rising upward.
// - Phase offset step size resets to 0x03E8, low byte lower address.
// - Sequence range 0x0E10..0x0E3F is plain bytes, no multi-byte packing.
// - Buffered registers stage writes until an update copies them active.
// - Update from writing 1 to update bit 0 or pin active edge.
// - Serial-class transfer happens on the update event in core clock.
// - System-clock class transfer waits for the divide-by-32 tick.
// - Live registers act on writes at once, no staging copy.
// - Readback select 0 reads active copy, 1 reads staged copy; the EEPROM port always reads the staged copy.
// - Read-only snapshot refreshes only at an update event.
// - Autoclear bit takes effect at update, cleared when action completes.
// - Several classes on one register: strongest restriction applies.
// - Denied or unmapped: reads give zero, writes discarded.
// - Serial or EEPROM master, one at a time; EEPROM exclusive when busy.
// - Read-only registers stay readable while EEPROM busy.
// - EEPROM-excluded and read-only registers never reach the EEPROM.
`include "buffered_register_map_params.svh"
`default_nettype none

module buffered_register_map_core
  import buffered_register_map_pkg::*;
#(
  parameter logic [7:0] SILICON_REV = 8'h01, // Arbitrary value
  parameter logic [7:0] PART_ID     = 8'h5A, // Arbitrary value
  parameter int         DIVIDE      = `SYSTEM_CLOCK_DIVIDE
) (
  // Clock, reset, enable
  input  wire  logic       i_core_clk,
  input  wire  logic       i_resetn,
  input  wire  logic       i_clk_en,
  // Serial host port
  input  wire  bus_req_t   i_host_req,
  output var   logic [7:0] o_host_rdata,
  output var   logic       o_host_rvalid,
  // EEPROM controller port
  input  wire  logic       i_eeprom_busy,
  input  wire  bus_req_t   i_eeprom_req,
  output var   logic [7:0] o_eeprom_rdata,
  output var   logic       o_eeprom_rvalid,
  // Device side
  input  wire  logic       i_update_pin,
  input  wire  logic       i_action_done,
  input  wire  logic [7:0] i_status,
  output var   logic [7:0] o_port_config,
  output var   logic [15:0] o_step_size,
  output var   logic [7:0] o_slow_control,
  output var   logic       o_update_event
);

  localparam int DIV_W = $clog2(DIVIDE);

  // Elaboration check: the free divider only wraps cleanly at a power of two
  if (DIVIDE < 2 || (DIVIDE & (DIVIDE - 1)) != 0) begin : g_bad_divide
    $error("DIVIDE must be a power of two of at least 2");
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0]    port_config_reg;
  logic [7:0]    spare_reg;
  logic [7:0]    readback_reg;
  logic          update_bit_reg;
  logic [15:0]   step_staged_reg;
  logic [15:0]   step_active_reg;
  logic [7:0]    slow_staged_reg;
  logic [7:0]    slow_active_reg;
  logic [7:0]    status_snap_reg;
  logic [7:0]    seq_mem [`ADDR_SEQ_FIRST:`ADDR_SEQ_LAST];
  logic          pin_q_reg;
  logic [DIV_W-1:0] div_reg;
  commit_state_t commit_reg;

  // ----------------------------------------
  // Access classes
  // ----------------------------------------
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a <= `MAP_LAST_ADDR) &&
                (a <= `ADDR_UPDATE || a == `ADDR_STEP_LOW || a == `ADDR_STEP_HIGH ||
                 a == `ADDR_SLOW_CONTROL || a == `ADDR_STATUS_SNAP ||
                 (a >= `ADDR_SEQ_FIRST && a <= `ADDR_SEQ_LAST));
  endfunction

  function automatic logic is_ro(input logic [15:0] a);
    is_ro = (a == `ADDR_SILICON_REV) || (a == `ADDR_PART_ID) || (a == `ADDR_STATUS_SNAP);
  endfunction

  function automatic logic is_eeprom_excl(input logic [15:0] a);
    is_eeprom_excl = (a <= `ADDR_UPDATE);
  endfunction

  // Most restrictive class wins: each class can only remove access
  function automatic logic allowed(input logic [15:0] a, input logic eeprom, input logic busy);
    logic ok;
    ok = is_mapped(a);
    if (eeprom) begin
      ok = ok && busy && !is_ro(a) && !is_eeprom_excl(a);
    end else if (busy) begin
      ok = ok && is_ro(a);
    end
    allowed = ok;
  endfunction

  function automatic logic [7:0] read_byte(input logic [15:0] a, input logic staged_sel);
    logic [7:0] d;
    d = 8'h00;
    if (a >= `ADDR_SEQ_FIRST && a <= `ADDR_SEQ_LAST) begin
      d = seq_mem[a];
    end else begin
      unique case (a)
        `ADDR_PORT_CONFIG:  d = port_config_reg;
        `ADDR_SPARE_ONE:    d = spare_reg;
        `ADDR_SILICON_REV:  d = SILICON_REV;
        `ADDR_PART_ID:      d = PART_ID;
        `ADDR_READBACK_SEL: d = readback_reg;
        `ADDR_UPDATE:       d = {7'h00, update_bit_reg};
        `ADDR_STEP_LOW:     d = staged_sel ? step_staged_reg[7:0] : step_active_reg[7:0];
        `ADDR_STEP_HIGH:    d = staged_sel ? step_staged_reg[15:8] : step_active_reg[15:8];
        `ADDR_SLOW_CONTROL: d = staged_sel ? slow_staged_reg : slow_active_reg;
        `ADDR_STATUS_SNAP:  d = status_snap_reg;
        default:            d = 8'h00;
      endcase
    end
    read_byte = d;
  endfunction

  // ----------------------------------------
  // Write arbitration
  // ----------------------------------------
  logic        host_wr_ok;
  logic        eeprom_wr_ok;
  logic        wr_en;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic        upd_evt;
  logic        tick;
  logic        staged_sel;

  assign host_wr_ok   = i_host_req.wr && allowed(i_host_req.addr, 1'b0, i_eeprom_busy);
  assign eeprom_wr_ok = i_eeprom_req.wr && allowed(i_eeprom_req.addr, 1'b1, i_eeprom_busy);
  // Both sources pass allowed() together only while busy with a host read-only address; the EEPROM write then wins
  assign wr_en   = host_wr_ok || eeprom_wr_ok;
  assign wr_addr = eeprom_wr_ok ? i_eeprom_req.addr : i_host_req.addr;
  assign wr_data = eeprom_wr_ok ? i_eeprom_req.wdata : i_host_req.wdata;
  assign staged_sel = readback_reg[`BIT_READBACK_STAGED];

  // Pin is taken as synchronous; rising edge means the active level arrived
  assign upd_evt = (wr_en && wr_addr == `ADDR_UPDATE && wr_data[`BIT_UPDATE_TRIGGER]) ||
                   (i_update_pin && !pin_q_reg);
  assign tick    = (div_reg == DIV_W'(DIVIDE - 1));

  // ----------------------------------------
  // Live registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      port_config_reg <= `RST_PORT_CONFIG;
      spare_reg       <= `RST_SPARE_ONE;
      readback_reg    <= `RST_READBACK_SEL;
    end else if (i_clk_en && wr_en) begin
      // Writes act at once, no staging copy
      if (wr_addr == `ADDR_PORT_CONFIG) begin
        port_config_reg <= wr_data;
      end
      if (wr_addr == `ADDR_SPARE_ONE) begin
        spare_reg <= wr_data;
      end
      if (wr_addr == `ADDR_READBACK_SEL) begin
        readback_reg <= wr_data;
      end
    end
  end

  // Sequence bytes are kept individually, never packed
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = `ADDR_SEQ_FIRST; i <= `ADDR_SEQ_LAST; i++) begin
        seq_mem[i] <= `RST_SEQ_BYTE;
      end
    end else if (i_clk_en && wr_en && wr_addr >= `ADDR_SEQ_FIRST && wr_addr <= `ADDR_SEQ_LAST) begin
      seq_mem[wr_addr] <= wr_data;
    end
  end

  // ----------------------------------------
  // Staged registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      step_staged_reg <= `RST_STEP_SIZE;
      slow_staged_reg <= `RST_SLOW_CONTROL;
    end else if (i_clk_en && wr_en) begin
      if (wr_addr == `ADDR_STEP_LOW) begin
        step_staged_reg[7:0] <= wr_data;
      end
      if (wr_addr == `ADDR_STEP_HIGH) begin
        step_staged_reg[15:8] <= wr_data;
      end
      if (wr_addr == `ADDR_SLOW_CONTROL) begin
        slow_staged_reg <= wr_data;
      end
    end
  end

  // ----------------------------------------
  // Serial-class commit and snapshot
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      step_active_reg <= `RST_STEP_SIZE;
      status_snap_reg <= `RST_STATUS_SNAP;
      pin_q_reg       <= 1'b0;
    end else if (i_clk_en) begin
      pin_q_reg <= i_update_pin;
      if (upd_evt) begin
        step_active_reg <= step_staged_reg;
        status_snap_reg <= i_status;
      end
    end
  end

  // ----------------------------------------
  // System-clock class commit
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg <= '0;
    end else if (i_clk_en) begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      commit_reg <= COMMIT_IDLE;
    end else if (i_clk_en) begin
      unique case (commit_reg)
        COMMIT_IDLE:    commit_reg <= upd_evt ? COMMIT_PENDING : COMMIT_IDLE;
        // A new update during the tick keeps the request alive
        COMMIT_PENDING: commit_reg <= (tick && !upd_evt) ? COMMIT_IDLE : COMMIT_PENDING;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      slow_active_reg <= `RST_SLOW_CONTROL;
    end else if (i_clk_en) begin
      if (commit_reg == COMMIT_PENDING && tick) begin
        // Commit wins over a completion in the same cycle
        slow_active_reg <= slow_staged_reg;
      end else if (i_action_done) begin
        slow_active_reg[`BIT_ACTION_REQUEST] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      update_bit_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (upd_evt) begin
        update_bit_reg <= 1'b1;
      end else if (commit_reg == COMMIT_IDLE || tick) begin
        update_bit_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read ports and outputs
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_host_rdata    <= 8'h00;
      o_host_rvalid   <= 1'b0;
      o_eeprom_rdata  <= 8'h00;
      o_eeprom_rvalid <= 1'b0;
    end else if (i_clk_en) begin
      o_host_rvalid   <= i_host_req.rd;
      o_eeprom_rvalid <= i_eeprom_req.rd;
      o_host_rdata    <= allowed(i_host_req.addr, 1'b0, i_eeprom_busy) ?
                         read_byte(i_host_req.addr, staged_sel) : 8'h00;
      // EEPROM store always sees what it loads: the staged copy
      o_eeprom_rdata  <= allowed(i_eeprom_req.addr, 1'b1, i_eeprom_busy) ?
                         read_byte(i_eeprom_req.addr, 1'b1) : 8'h00;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_port_config  <= `RST_PORT_CONFIG;
      o_step_size    <= `RST_STEP_SIZE;
      o_slow_control <= `RST_SLOW_CONTROL;
      o_update_event <= 1'b0;
    end else if (i_clk_en) begin
      o_port_config  <= port_config_reg;
      o_step_size    <= step_active_reg;
      o_slow_control <= slow_active_reg;
      o_update_event <= upd_evt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  a_step_commit_copy: assert property (i_clk_en && upd_evt |=> step_active_reg == $past(step_staged_reg))
    else $error("step size not committed on update");
  a_step_hold_idle: assert property (i_clk_en && !upd_evt |=> $stable(step_active_reg))
    else $error("step size active changed without update");
  a_slow_commit_bound: assert property (
    i_clk_en && upd_evt ##1 i_clk_en[*8] ##0 !upd_evt [*1]
    |-> ##[0:40] (commit_reg == COMMIT_IDLE || !i_clk_en || upd_evt))
    else $error("system clock class commit overdue");
  a_slow_on_tick: assert property (
    i_clk_en && !(commit_reg == COMMIT_PENDING && tick)
    |=> slow_active_reg[7:1] == $past(slow_active_reg[7:1]))
    else $error("system clock class changed off tick");
  a_unmapped_zero: assert property (
    i_clk_en && i_host_req.rd && !is_mapped(i_host_req.addr)
    |=> o_host_rvalid && o_host_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_busy_blocks_host: assert property (
    i_clk_en && i_eeprom_busy && !i_eeprom_req.wr
    |=> $stable(readback_reg) && $stable(step_staged_reg))
    else $error("host write landed while eeprom busy");
  a_ro_readable: assert property (
    i_clk_en && i_host_req.rd && i_host_req.addr == `ADDR_PART_ID
    |=> o_host_rdata == PART_ID)
    else $error("part id unreadable");
  a_eeprom_excluded: assert property (
    i_clk_en && !i_host_req.wr && i_eeprom_req.wr && is_eeprom_excl(i_eeprom_req.addr)
    |=> $stable(port_config_reg) && $stable(readback_reg))
    else $error("eeprom reached excluded register");
  a_autoclear_done: assert property (
    i_clk_en && i_action_done && !(commit_reg == COMMIT_PENDING && tick)
    |=> !slow_active_reg[`BIT_ACTION_REQUEST])
    else $error("action bit not cleared");
  a_readback_staged: assert property (
    i_clk_en && i_host_req.rd && i_host_req.addr == `ADDR_STEP_LOW && staged_sel && !i_eeprom_busy
    |=> o_host_rdata == $past(step_staged_reg[7:0]))
    else $error("readback select ignored");
  a_update_bit_clear: assert property (
    i_clk_en && update_bit_reg && commit_reg == COMMIT_PENDING && tick && !upd_evt
    |=> !update_bit_reg)
    else $error("update bit stuck");

  c_pin_update: cover property (i_clk_en && i_update_pin && !pin_q_reg);
  c_slow_commit: cover property (i_clk_en && commit_reg == COMMIT_PENDING && tick);
  c_eeprom_write: cover property (i_clk_en && eeprom_wr_ok);
  c_denied_host: cover property (i_clk_en && i_host_req.wr && i_eeprom_busy);

endmodule

`default_nettype wire

// [eeprom_ctrl_model.sv]
`default_nettype none

module eeprom_ctrl_model
  import buffered_register_map_pkg::*;
(
  // Clock
  input  wire logic       i_core_clk,
  // Register map side
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output var  logic       o_busy,
  output var  bus_req_t   o_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_busy = 1'b0;
    o_req  = '0;
  end

  // ----
  // Ownership and byte cycles
  // ----
  // Busy level marks the exclusive load or store window
  task automatic hold_bus(input logic on);
    @(negedge i_core_clk);
    o_busy = on;
  endtask

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_req = '0;
  endtask

  // Answer stands one cycle, so it is taken at the next falling edge
  task automatic get(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge i_core_clk);
    o_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge i_core_clk);
    v = i_rvalid;
    d = i_rdata;
    o_req = '0;
  endtask
endmodule

`default_nettype wire

// [test_buffered_register_map_core.sv]
`include "buffered_register_map_params.svh"
`default_nettype none

module test_buffered_register_map_core
  import buffered_register_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int         DIV = 4;
  localparam logic [7:0] REV = 8'h21; // Arbitrary value
  localparam logic [7:0] PID = 8'h6B; // Arbitrary value

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clk_en = 1'b1;
  bus_req_t    host_req = '0;
  logic [7:0]  host_rdata;
  logic        host_rvalid;
  logic        ee_busy;
  bus_req_t    ee_req;
  logic [7:0]  ee_rdata;
  logic        ee_rvalid;
  logic        upd_pin = 1'b0;
  logic        act_done = 1'b0;
  logic [7:0]  status = 8'h3C;
  logic [7:0]  port_cfg;
  logic [15:0] step;
  logic [7:0]  slow;
  logic        upd_evt;
  logic [7:0]  d;
  logic        v;
  int          err_total = 0;
  int          n_tests = 0;
  int          cycles = 0;

  buffered_register_map_core #(.SILICON_REV(REV), .PART_ID(PID), .DIVIDE(DIV)) i_buffered_register_map_core (
    .i_core_clk(clk), .i_resetn(resetn), .i_clk_en(clk_en),
    .i_host_req(host_req), .o_host_rdata(host_rdata), .o_host_rvalid(host_rvalid),
    .i_eeprom_busy(ee_busy), .i_eeprom_req(ee_req), .o_eeprom_rdata(ee_rdata),
    .o_eeprom_rvalid(ee_rvalid), .i_update_pin(upd_pin), .i_action_done(act_done),
    .i_status(status), .o_port_config(port_cfg), .o_step_size(step),
    .o_slow_control(slow), .o_update_event(upd_evt));

  eeprom_ctrl_model i_eeprom_ctrl_model (
    .i_core_clk(clk), .i_rdata(ee_rdata), .i_rvalid(ee_rvalid), .o_busy(ee_busy), .o_req(ee_req));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic host_wr(input logic [15:0] a, input logic [7:0] dt);
    @(negedge clk);
    host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: dt};
    @(negedge clk);
    host_req = '0;
  endtask

  task automatic host_rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    check({15'h0000, host_rvalid}, 16'h0001);
    check({8'h00, host_rdata}, {8'h00, exp});
    host_req = '0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    check({8'h00, port_cfg}, 16'h0010);
    check(step, 16'h03E8);
    host_rd(`ADDR_PORT_CONFIG, 8'h10);
    host_rd(`ADDR_SPARE_ONE, 8'h00);
    host_rd(`ADDR_SILICON_REV, REV);
    host_rd(`ADDR_PART_ID, PID);
    host_rd(`ADDR_READBACK_SEL, 8'h00);
    host_rd(`ADDR_STEP_LOW, 8'hE8);
    host_rd(`ADDR_STEP_HIGH, 8'h03);
  endtask

  task automatic t_buffered();
    host_wr(`ADDR_STEP_LOW, 8'h34);
    host_wr(`ADDR_STEP_HIGH, 8'h12);
    check(step, 16'h03E8);
    host_rd(`ADDR_STEP_LOW, 8'hE8);
    host_wr(`ADDR_READBACK_SEL, 8'h01);
    host_rd(`ADDR_STEP_LOW, 8'h34);
    host_rd(`ADDR_STEP_HIGH, 8'h12);
    host_wr(`ADDR_UPDATE, 8'h01);
    // Event pulse leads the step output by one cycle
    check({15'h0000, upd_evt}, 16'h0001);
    @(negedge clk);
    check(step, 16'h1234);
    check({15'h0000, upd_evt}, 16'h0000);
    host_wr(`ADDR_READBACK_SEL, 8'h00);
    host_rd(`ADDR_STEP_HIGH, 8'h12);
  endtask

  // Live write reaches the port config output one cycle after the register, no update needed
  task automatic t_live();
    host_wr(`ADDR_PORT_CONFIG, 8'h90);
    @(negedge clk);
    check({8'h00, port_cfg}, 16'h0090);
    host_wr(`ADDR_PORT_CONFIG, 8'h10);
  endtask

  // Tick phase is free running, so only the bound is judged
  task automatic t_slow();
    host_wr(`ADDR_SLOW_CONTROL, 8'h01);
    host_wr(`ADDR_UPDATE, 8'h01);
    @(negedge clk);
    // A serial-class commit would already show here
    check({8'h00, slow}, 16'h0000);
    for (int n = 0; n < DIV + 4 && slow !== 8'h01; n++) begin
      @(negedge clk);
    end
    check({8'h00, slow}, 16'h0001);
    host_rd(`ADDR_UPDATE, 8'h00);
    act_done = 1'b1;
    @(negedge clk);
    act_done = 1'b0;
    @(negedge clk);
    @(negedge clk);
    check({8'h00, slow}, 16'h0000);
  endtask

  // Level held high must give one event only
  task automatic t_pin();
    status = 8'hC3;
    host_rd(`ADDR_STATUS_SNAP, 8'h3C);
    upd_pin = 1'b1;
    @(negedge clk);
    check({15'h0000, upd_evt}, 16'h0001);
    @(negedge clk);
    check({15'h0000, upd_evt}, 16'h0000);
    upd_pin = 1'b0;
    host_rd(`ADDR_STATUS_SNAP, 8'hC3);
  endtask

  task automatic t_unmapped();
    host_wr(16'h0E40, 8'h5A);
    host_rd(16'h0E40, 8'h00);
    host_rd(16'h0100, 8'h00);
    host_wr(`ADDR_STATUS_SNAP, 8'hFF);
    host_rd(`ADDR_STATUS_SNAP, 8'hC3);
    host_wr(`ADDR_READBACK_SEL, 8'h01);
    host_wr(`ADDR_SEQ_FIRST, 8'h11);
    host_wr(16'h0E11, 8'h22);
    host_wr(`ADDR_SEQ_LAST, 8'h33);
    host_rd(`ADDR_SEQ_FIRST, 8'h11);
    host_rd(16'h0E11, 8'h22);
    host_rd(`ADDR_SEQ_LAST, 8'h33);
  endtask

  // Host is locked out of all but read-only registers while the controller owns the map
  task automatic t_eeprom();
    i_eeprom_ctrl_model.hold_bus(1'b1);
    host_wr(`ADDR_STEP_LOW, 8'h99);
    host_rd(`ADDR_STEP_LOW, 8'h00);
    host_rd(`ADDR_PART_ID, PID);
    host_rd(`ADDR_STATUS_SNAP, 8'hC3);
    i_eeprom_ctrl_model.put(`ADDR_STEP_LOW, 8'h77);
    i_eeprom_ctrl_model.get(`ADDR_STEP_LOW, d, v);
    check({15'h0000, v}, 16'h0001);
    check({8'h00, d}, 16'h0077);
    i_eeprom_ctrl_model.put(`ADDR_READBACK_SEL, 8'h00);
    i_eeprom_ctrl_model.get(`ADDR_PART_ID, d, v);
    check({8'h00, d}, 16'h0000);
    i_eeprom_ctrl_model.hold_bus(1'b0);
    host_rd(`ADDR_READBACK_SEL, 8'h01);
    host_rd(`ADDR_STEP_LOW, 8'h77);
  endtask

  // Staged low byte differs from active, so a leaked update would show
  task automatic t_freeze();
    @(negedge clk);
    clk_en = 1'b0;
    host_wr(`ADDR_UPDATE, 8'h01);
    check({15'h0000, upd_evt}, 16'h0000);
    check(step, 16'h1234);
    clk_en = 1'b1;
    @(negedge clk);
    check(step, 16'h1234);
  endtask

  // ----
  // Main sequence and hang guard
  // ----
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_buffered();
    t_live();
    t_slow();
    t_pin();
    t_unmapped();
    t_eeprom();
    t_freeze();
    tally_and_finish();
  end
endmodule

`default_nettype wire
